// file: rtl/mil_ctrl_top.sv
// Overview of operation
// - Identity byte zero always reads a fixed maker code, writes ignored.
// - Identity byte one reads a constant encoding flash size.
// - Identity byte two reads a constant encoding the device number.
// - Revision register gives revision in bits 3:0; bits 7:4 reserved.
// - Eight-bit scan user identifier is loaded automatically from flash.
// - Control bit 0 set disables the boundary-scan test interface.
// - Scan-disable and lock bits change only under the unlock sequence.
// - Each port's two-bit field enables sequential analog start-up.
// - Code 00 direct, 01 two, 10 eight, 11 thirty-two clocks.
// - Event lock bit 4 blocks writes to event channels 4 to 7.
// - Event lock bit 0 blocks writes to event channels 0 to 3.
// - Wave lock bit 2 blocks writes to timer E0 waveform extension.
// - Wave lock bit 0 blocks writes to timer C0 waveform extension.
`timescale 1ns/1ns
`default_nettype none
`include "mil_map.svh"

module mil_ctrl_top #(
  parameter logic [7:0] IDENT0 = 8'h5a, // Arbitrary value
  parameter logic [7:0] IDENT1 = 8'h94, // Arbitrary value
  parameter logic [7:0] IDENT2 = 8'h42, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h0, // Arbitrary value
  parameter int NPORTS = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mil_pkg::mil_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic uid_load_i,
  input wire logic [7:0] uid_flash_i,
  input wire logic [NPORTS-1:0] ana_en_i,
  output logic [NPORTS-1:0] ana_ref_o,
  output logic [NPORTS-1:0] ana_bias_o,
  output logic scan_port_disable_o,
  output logic upper_channels_lock_o,
  output logic lower_channels_lock_o,
  output logic timer_e0_wave_lock_o,
  output logic timer_c0_wave_lock_o,
  input wire logic [7:0] evt_wr_i,
  output logic [7:0] evt_wr_ok_o,
  input wire logic [1:0] wave_wr_i,
  output logic [1:0] wave_wr_ok_o
);

  // Two ports fill the four delay bits
  if (NPORTS < 1 || NPORTS > 2) begin : g_bad_ports
    $error("NPORTS must be 1 or 2");
  end

  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic req;
  logic wr;
  logic ccp_open;
  logic key_wr;
  logic prot_wr;
  logic [7:0] uid_q;
  logic [7:0] ana_q;
  logic scan_q;
  logic ev_hi_q;
  logic ev_lo_q;
  logic wv_e_q;
  logic wv_c_q;
  logic [7:0] evt_ok_q;
  logic [1:0] wave_ok_q;
  mil_pkg::mil_ana_out_t ana_out [NPORTS];

  // New request only while no answer is pending, so a held cycle acts once
  assign req = wb_i.cyc && wb_i.stb && !ack_q;
  assign wr = req && wb_i.we && wb_i.sel[0];
  assign key_wr = wr && wb_i.adr == `MIL_OFS_CCPKEY && wb_i.dat[7:0] == `MIL_CCP_KEY;
  assign prot_wr = wr && ccp_open;

  mil_ccp_unlock u_ccp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .key_wr_i(key_wr),
    .open_o(ccp_open)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Unmapped offsets answer with zero and drop writes
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (wb_i.adr)
      `MIL_OFS_IDENT0: rd_d[7:0] = IDENT0;
      `MIL_OFS_IDENT1: rd_d[7:0] = IDENT1;
      `MIL_OFS_IDENT2: rd_d[7:0] = IDENT2;
      `MIL_OFS_REV: rd_d[3:0] = REVISION;
      `MIL_OFS_UID: rd_d[7:0] = uid_q;
      `MIL_OFS_MCUCTL: rd_d[`MIL_SCAN_DIS_BIT] = scan_q;
      `MIL_OFS_ANA: rd_d[7:0] = ana_q & `MIL_ANA_MASK;
      `MIL_OFS_EVLOCK: begin
        rd_d[`MIL_EV_HI_BIT] = ev_hi_q;
        rd_d[`MIL_EV_LO_BIT] = ev_lo_q;
      end
      `MIL_OFS_WVLOCK: begin
        rd_d[`MIL_WV_E0_BIT] = wv_e_q;
        rd_d[`MIL_WV_C0_BIT] = wv_c_q;
      end
      `MIL_OFS_CCPKEY: rd_d[`MIL_CCP_OPEN_BIT] = ccp_open;
      `MIL_OFS_ANASTAT: begin
        for (int p = 0; p < NPORTS; p++) begin
          rd_d[p] = ana_out[p].bias_on;
          rd_d[p+4] = ana_out[p].ref_on;
        end
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !wb_i.we) begin
      dat_q <= rd_d;
    end
  end

  // Flash loader presents the identifier after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uid_q <= `MIL_RST_VAL;
    end else if (uid_load_i) begin
      uid_q <= uid_flash_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_q <= `MIL_RST_VAL;
    end else if (wr && wb_i.adr == `MIL_OFS_ANA) begin
      ana_q <= wb_i.dat[7:0] & `MIL_ANA_MASK;
    end
  end

  // Scan disable may be cleared again, unlike the lock bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_q <= 1'b0;
    end else if (prot_wr && wb_i.adr == `MIL_OFS_MCUCTL) begin
      scan_q <= wb_i.dat[`MIL_SCAN_DIS_BIT];
    end
  end

  // Lock bits only ever set; reset is the sole way out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_hi_q <= 1'b0;
      ev_lo_q <= 1'b0;
    end else if (prot_wr && wb_i.adr == `MIL_OFS_EVLOCK) begin
      ev_hi_q <= ev_hi_q | wb_i.dat[`MIL_EV_HI_BIT];
      ev_lo_q <= ev_lo_q | wb_i.dat[`MIL_EV_LO_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wv_e_q <= 1'b0;
      wv_c_q <= 1'b0;
    end else if (prot_wr && wb_i.adr == `MIL_OFS_WVLOCK) begin
      wv_e_q <= wv_e_q | wb_i.dat[`MIL_WV_E0_BIT];
      wv_c_q <= wv_c_q | wb_i.dat[`MIL_WV_C0_BIT];
    end
  end

  // Write strobes toward the protected units pass one flop, costing a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_ok_q <= 8'h00;
    end else begin
      evt_ok_q[7:4] <= evt_wr_i[7:4] & {4{!ev_hi_q}};
      evt_ok_q[3:0] <= evt_wr_i[3:0] & {4{!ev_lo_q}};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wave_ok_q <= 2'b00;
    end else begin
      wave_ok_q[1] <= wave_wr_i[1] && !wv_e_q;
      wave_ok_q[0] <= wave_wr_i[0] && !wv_c_q;
    end
  end

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    mil_start_seq u_seq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(ana_en_i[p]),
      .code_i(ana_q[2*p+1:2*p]),
      .out_o(ana_out[p])
    );
    assign ana_ref_o[p] = ana_out[p].ref_on;
    assign ana_bias_o[p] = ana_out[p].bias_on;
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign scan_port_disable_o = scan_q;
  assign upper_channels_lock_o = ev_hi_q;
  assign lower_channels_lock_o = ev_lo_q;
  assign timer_e0_wave_lock_o = wv_e_q;
  assign timer_c0_wave_lock_o = wv_c_q;
  assign evt_wr_ok_o = evt_ok_q;
  assign wave_wr_ok_o = wave_ok_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ident0;
    wb_ack_o && !wb_i.we && wb_i.adr == `MIL_OFS_IDENT0 |-> wb_dat_o == {24'h0, IDENT0};
  endproperty
  a_ident0: assert property (p_ident0) else $error("identity byte zero wrong");

  property p_ident1;
    wb_ack_o && !wb_i.we && wb_i.adr == `MIL_OFS_IDENT1 |-> wb_dat_o == {24'h0, IDENT1};
  endproperty
  a_ident1: assert property (p_ident1) else $error("identity byte one wrong");

  property p_ident2;
    wb_ack_o && !wb_i.we && wb_i.adr == `MIL_OFS_IDENT2 |-> wb_dat_o == {24'h0, IDENT2};
  endproperty
  a_ident2: assert property (p_ident2) else $error("identity byte two wrong");

  property p_rev;
    wb_ack_o && !wb_i.we && wb_i.adr == `MIL_OFS_REV |-> wb_dat_o == {28'h0, REVISION};
  endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");

  property p_uid_load;
    uid_load_i |=> uid_q == $past(uid_flash_i);
  endproperty
  a_uid_load: assert property (p_uid_load) else $error("user identifier not loaded");

  property p_scan_set;
    wr && ccp_open && wb_i.adr == `MIL_OFS_MCUCTL && wb_i.dat[0]
      |=> scan_port_disable_o ##1 wb_ack_o == 1'b0;
  endproperty
  a_scan_set: assert property (p_scan_set) else $error("scan disable not set");

  property p_locked_out;
    wr && !ccp_open && (wb_i.adr == `MIL_OFS_EVLOCK || wb_i.adr == `MIL_OFS_WVLOCK
      || wb_i.adr == `MIL_OFS_MCUCTL) |=> $stable({scan_q, ev_hi_q, ev_lo_q, wv_e_q, wv_c_q});
  endproperty
  a_locked_out: assert property (p_locked_out) else $error("write passed without unlock");

  property p_ev_hi;
    upper_channels_lock_o |=> evt_wr_ok_o[7:4] == 4'h0;
  endproperty
  a_ev_hi: assert property (p_ev_hi) else $error("upper event channels not locked");

  property p_ev_lo;
    !lower_channels_lock_o && evt_wr_i[0] ##1 lower_channels_lock_o |-> evt_wr_ok_o[0];
  endproperty
  a_ev_lo: assert property (p_ev_lo) else $error("lower lock timing wrong");

  property p_ev_lo_block;
    lower_channels_lock_o |=> evt_wr_ok_o[3:0] == 4'h0;
  endproperty
  a_ev_lo_block: assert property (p_ev_lo_block) else $error("lower lock ignored");

  property p_wv_e;
    timer_e0_wave_lock_o |=> !wave_wr_ok_o[1];
  endproperty
  a_wv_e: assert property (p_wv_e) else $error("timer E0 extension not locked");

  property p_wv_c;
    !timer_c0_wave_lock_o && wave_wr_i[0] |=> wave_wr_ok_o[0];
  endproperty
  a_wv_c: assert property (p_wv_c) else $error("unlocked C0 write dropped");

  property p_wv_c_block;
    timer_c0_wave_lock_o |=> !wave_wr_ok_o[0];
  endproperty
  a_wv_c_block: assert property (p_wv_c_block) else $error("C0 extension not locked");

  property p_sticky;
    (ev_hi_q || ev_lo_q || wv_e_q || wv_c_q) |=>
      ({ev_hi_q, ev_lo_q, wv_e_q, wv_c_q} & $past({ev_hi_q, ev_lo_q, wv_e_q, wv_c_q}))
        == $past({ev_hi_q, ev_lo_q, wv_e_q, wv_c_q});
  endproperty
  a_sticky: assert property (p_sticky) else $error("lock bit cleared without reset");

  property p_read_locked;
    wb_ack_o && !wb_i.we && wb_i.adr == `MIL_OFS_EVLOCK && ev_lo_q |-> wb_dat_o[0];
  endproperty
  a_read_locked: assert property (p_read_locked) else $error("lock state not readable");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");

  property p_ev_hi_pass;
    !upper_channels_lock_o && evt_wr_i[4] |=> evt_wr_ok_o[4];
  endproperty
  a_ev_hi_pass: assert property (p_ev_hi_pass) else $error("unlocked upper write dropped");

  property p_wv_e_pass;
    !timer_e0_wave_lock_o && wave_wr_i[1] |=> wave_wr_ok_o[1];
  endproperty
  a_wv_e_pass: assert property (p_wv_e_pass) else $error("unlocked E0 write dropped");

  property p_lock_set;
    prot_wr && wb_i.adr == `MIL_OFS_EVLOCK && wb_i.dat[`MIL_EV_HI_BIT]
      |=> upper_channels_lock_o;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("unlocked lock write lost");

  property p_uid_hold;
    !uid_load_i |=> $stable(uid_q);
  endproperty
  a_uid_hold: assert property (p_uid_hold) else $error("identifier changed without load");

  property p_ana_write;
    wr && wb_i.adr == `MIL_OFS_ANA |=> ana_q == ($past(wb_i.dat[7:0]) & `MIL_ANA_MASK);
  endproperty
  a_ana_write: assert property (p_ana_write) else $error("delay field not stored");

  property p_key_read;
    wb_ack_o && !wb_i.we && wb_i.adr == `MIL_OFS_CCPKEY && $past(ccp_open) |-> wb_dat_o[0];
  endproperty
  a_key_read: assert property (p_key_read) else $error("unlock state not readable");

  c_unlock_lock: cover property (key_wr ##[1:4] (prot_wr && wb_i.adr == `MIL_OFS_EVLOCK));
  c_ident_read: cover property (wb_ack_o && !wb_i.we && wb_i.adr == `MIL_OFS_IDENT0);
  c_port_up: cover property ($rose(ana_bias_o[0]));
  c_locked_drop: cover property (evt_wr_i[5] && upper_channels_lock_o);
  c_scan_clear: cover property ($fell(scan_port_disable_o));

endmodule

`default_nettype wire

// file: rtl/mil_map.svh
`ifndef MIL_MAP_SVH
`define MIL_MAP_SVH

// Register byte offsets, one aligned word each
`define MIL_OFS_IDENT0 8'h00
`define MIL_OFS_IDENT1 8'h04
`define MIL_OFS_IDENT2 8'h08
`define MIL_OFS_REV 8'h0c
`define MIL_OFS_UID 8'h10
`define MIL_OFS_MCUCTL 8'h14
`define MIL_OFS_ANA 8'h18
`define MIL_OFS_EVLOCK 8'h1c
`define MIL_OFS_WVLOCK 8'h20
`define MIL_OFS_CCPKEY 8'h24
`define MIL_OFS_ANASTAT 8'h28

// Field positions
`define MIL_SCAN_DIS_BIT 0
`define MIL_EV_HI_BIT 4
`define MIL_EV_LO_BIT 0
`define MIL_WV_E0_BIT 2
`define MIL_WV_C0_BIT 0
`define MIL_CCP_OPEN_BIT 0

// Writable bits and reset values
`define MIL_MCU_MASK 8'h01
`define MIL_ANA_MASK 8'h0f
`define MIL_EV_MASK 8'h11
`define MIL_WV_MASK 8'h05
`define MIL_RST_VAL 8'h00
`define MIL_REV_MASK 8'h0f

// Protection unlock
`define MIL_CCP_KEY 8'hd8
`define MIL_CCP_WINDOW 3'd4

// Start-up delay codes and their spacing in peripheral clocks
`define MIL_DLY_NONE 2'b00
`define MIL_DLY_C2 2'b01
`define MIL_DLY_C8 2'b10
`define MIL_DLY_C32 2'b11
`define MIL_DLY_N2 6'd2
`define MIL_DLY_N8 6'd8
`define MIL_DLY_N32 6'd32

`endif

// file: rtl/mil_pkg.sv
package mil_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } mil_wb_req_t;

  typedef struct packed {
    logic ref_on;
    logic bias_on;
  } mil_ana_out_t;

  typedef enum logic [1:0] {
    MIL_SEQ_IDLE = 2'b00,
    MIL_SEQ_WAIT = 2'b01,
    MIL_SEQ_UP = 2'b10
  } mil_seq_state_t;

endpackage

// file: rtl/mil_ccp_unlock.sv
`timescale 1ns/1ns
`default_nettype none
`include "mil_map.svh"

module mil_ccp_unlock (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic key_wr_i,
  output logic open_o
);

  logic [2:0] cnt_q;

  // Window restarts on every key write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 3'd0;
    end else if (key_wr_i) begin
      cnt_q <= `MIL_CCP_WINDOW;
    end else if (cnt_q != 3'd0) begin
      cnt_q <= cnt_q - 3'd1;
    end
  end

  assign open_o = (cnt_q != 3'd0);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ccp_window;
    key_wr_i ##1 !key_wr_i [*4] |-> open_o [*1] ##0 $past(open_o, 3) ##1 !open_o;
  endproperty
  a_ccp_window: assert property (p_ccp_window) else $error("unlock window length wrong");

  property p_ccp_closed;
    !open_o && !key_wr_i |=> !open_o;
  endproperty
  a_ccp_closed: assert property (p_ccp_closed) else $error("window opened without key");

endmodule

`default_nettype wire

// file: rtl/mil_start_seq.sv
`timescale 1ns/1ns
`default_nettype none
`include "mil_map.svh"

module mil_start_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [1:0] code_i,
  output mil_pkg::mil_ana_out_t out_o
);

  mil_pkg::mil_seq_state_t state_q;
  logic [5:0] cnt_q;
  logic [5:0] dly_q;
  logic [5:0] gap_q;

  function automatic logic [5:0] dly_of(input logic [1:0] code);
    unique case (code)
      `MIL_DLY_C2: dly_of = `MIL_DLY_N2;
      `MIL_DLY_C8: dly_of = `MIL_DLY_N8;
      `MIL_DLY_C32: dly_of = `MIL_DLY_N32;
      `MIL_DLY_NONE: dly_of = 6'd0;
    endcase
  endfunction

  // Code is latched at start; a change mid-sequence waits for the next enable
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      state_q <= mil_pkg::MIL_SEQ_IDLE;
      out_o <= '0;
      cnt_q <= 6'd0;
      dly_q <= 6'd0;
    end else begin
      unique case (state_q)
        mil_pkg::MIL_SEQ_IDLE: begin
          dly_q <= dly_of(code_i);
          out_o.ref_on <= 1'b1;
          if (code_i == `MIL_DLY_NONE) begin
            out_o.bias_on <= 1'b1;
            state_q <= mil_pkg::MIL_SEQ_UP;
          end else begin
            cnt_q <= dly_of(code_i) - 6'd1;
            state_q <= mil_pkg::MIL_SEQ_WAIT;
          end
        end
        mil_pkg::MIL_SEQ_WAIT: begin
          if (cnt_q == 6'd0) begin
            out_o.bias_on <= 1'b1;
            state_q <= mil_pkg::MIL_SEQ_UP;
          end else begin
            cnt_q <= cnt_q - 6'd1;
          end
        end
        mil_pkg::MIL_SEQ_UP: state_q <= mil_pkg::MIL_SEQ_UP;
        default: state_q <= mil_pkg::MIL_SEQ_IDLE;
      endcase
    end
  end

  // Checker only: cycles since reference came on
  always_ff @(posedge clk_i) begin
    if (rst_i || !out_o.ref_on) begin
      gap_q <= 6'd0;
    end else if (gap_q != 6'h3f) begin
      gap_q <= gap_q + 6'd1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_seq_gap;
    $rose(out_o.bias_on) && $past(out_o.ref_on) |-> gap_q == dly_q;
  endproperty
  a_seq_gap: assert property (p_seq_gap) else $error("start-up spacing wrong");

  property p_seq_code8;
    state_q == mil_pkg::MIL_SEQ_WAIT && $past(state_q) == mil_pkg::MIL_SEQ_IDLE
      && $past(code_i) == `MIL_DLY_C8 |-> dly_q == 6'd8;
  endproperty
  a_seq_code8: assert property (p_seq_code8) else $error("code 10 not eight clocks");

  property p_seq_direct;
    en_i && !out_o.ref_on && code_i == `MIL_DLY_NONE |=> out_o.ref_on && out_o.bias_on;
  endproperty
  a_seq_direct: assert property (p_seq_direct) else $error("direct start not direct");

endmodule

`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "mil_map.svh"

module tb_top;
  localparam logic [7:0] ID0 = 8'h3c; // Arbitrary value
  localparam logic [7:0] ID1 = 8'h71; // Arbitrary value
  localparam logic [7:0] ID2 = 8'h26; // Arbitrary value
  localparam logic [3:0] REV = 4'h3; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  mil_pkg::mil_wb_req_t wb_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic uid_load_i = 1'b0;
  logic [7:0] uid_flash_i = 8'h00;
  logic [1:0] ana_en_i = 2'b00;
  logic [1:0] ana_ref_o;
  logic [1:0] ana_bias_o;
  logic scan_port_disable_o;
  logic upper_channels_lock_o;
  logic lower_channels_lock_o;
  logic timer_e0_wave_lock_o;
  logic timer_c0_wave_lock_o;
  logic [7:0] evt_wr_i = 8'h00;
  logic [7:0] evt_wr_ok_o;
  logic [1:0] wave_wr_i = 2'b00;
  logic [1:0] wave_wr_ok_o;
  int err_total = 0;
  int num_checks = 0;

  always #5 clk_i = ~clk_i;

  mil_ctrl_top #(.IDENT0(ID0), .IDENT1(ID1), .IDENT2(ID2), .REVISION(REV), .NPORTS(2))
  mil_ctrl_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .uid_load_i(uid_load_i), .uid_flash_i(uid_flash_i),
    .ana_en_i(ana_en_i), .ana_ref_o(ana_ref_o), .ana_bias_o(ana_bias_o),
    .scan_port_disable_o(scan_port_disable_o), .upper_channels_lock_o(upper_channels_lock_o),
    .lower_channels_lock_o(lower_channels_lock_o), .timer_e0_wave_lock_o(timer_e0_wave_lock_o),
    .timer_c0_wave_lock_o(timer_c0_wave_lock_o), .evt_wr_i(evt_wr_i),
    .evt_wr_ok_o(evt_wr_ok_o), .wave_wr_i(wave_wr_i), .wave_wr_ok_o(wave_wr_ok_o));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Classic cycle, held until ack is sampled, then released for a cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, we, 4'hf, adr, dat};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      chk(32'h1, 32'h0, "no ack");
    end
    rd = wb_dat_o;
    wb_i <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] junk;
    wb_xfer(1'b1, adr, dat, junk);
  endtask

  task automatic rchk(input logic [7:0] adr, input logic [7:0] exp, input string what);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 32'h0, rd);
    chk(rd, {24'h0, exp}, what);
  endtask

  task automatic unlock;
    wr(`MIL_OFS_CCPKEY, 32'h000000d8);
  endtask

  task automatic strobe(input logic [7:0] ev, input logic [1:0] wv,
                        input logic [7:0] ev_exp, input logic [1:0] wv_exp);
    @(posedge clk_i);
    evt_wr_i <= ev;
    wave_wr_i <= wv;
    @(posedge clk_i);
    evt_wr_i <= 8'h00;
    wave_wr_i <= 2'b00;
    #1;
    chk({24'h0, evt_wr_ok_o}, {24'h0, ev_exp}, "event strobe");
    chk({30'h0, wave_wr_ok_o}, {30'h0, wv_exp}, "wave strobe");
    @(posedge clk_i);
    #1;
    chk({22'h0, evt_wr_ok_o, wave_wr_ok_o}, 32'h0, "strobe one cycle");
  endtask

  task automatic t_id;
    // Read-only bytes must shrug off writes
    wr(`MIL_OFS_IDENT0, 32'hff);
    wr(`MIL_OFS_IDENT1, 32'hff);
    wr(`MIL_OFS_IDENT2, 32'hff);
    wr(`MIL_OFS_REV, 32'hff);
    rchk(`MIL_OFS_IDENT0, ID0, "ident0");
    rchk(`MIL_OFS_IDENT1, ID1, "ident1");
    rchk(`MIL_OFS_IDENT2, ID2, "ident2");
    rchk(`MIL_OFS_REV, {4'h0, REV}, "revision");
    $display("test id done");
  endtask

  task automatic t_uid;
    rchk(`MIL_OFS_UID, 8'h00, "uid before load");
    @(posedge clk_i);
    uid_load_i <= 1'b1;
    uid_flash_i <= 8'ha7;
    @(posedge clk_i);
    uid_load_i <= 1'b0;
    uid_flash_i <= 8'h5e;
    wr(`MIL_OFS_UID, 32'h11);
    rchk(`MIL_OFS_UID, 8'ha7, "uid loaded");
    $display("test uid done");
  endtask

  task automatic t_scan;
    wr(`MIL_OFS_MCUCTL, 32'h01);
    rchk(`MIL_OFS_MCUCTL, 8'h00, "scan bit without unlock");
    chk(32'(scan_port_disable_o), 32'h0, "scan out without unlock");
    unlock();
    wr(`MIL_OFS_MCUCTL, 32'h01);
    rchk(`MIL_OFS_MCUCTL, 8'h01, "scan bit set");
    chk(32'(scan_port_disable_o), 32'h1, "scan out set");
    // Window of four edges has run out by the time of the write
    unlock();
    repeat (4) @(posedge clk_i);
    wr(`MIL_OFS_MCUCTL, 32'h00);
    rchk(`MIL_OFS_MCUCTL, 8'h01, "write after window");
    unlock();
    wr(`MIL_OFS_MCUCTL, 32'h00);
    chk(32'(scan_port_disable_o), 32'h0, "scan out cleared");
    unlock();
    rchk(`MIL_OFS_CCPKEY, 8'h01, "window open");
    rchk(`MIL_OFS_CCPKEY, 8'h00, "window closed");
    $display("test scan done");
  endtask

  task automatic t_locks;
    strobe(8'hff, 2'b11, 8'hff, 2'b11);
    wr(`MIL_OFS_EVLOCK, 32'h01);
    strobe(8'hff, 2'b11, 8'hff, 2'b11);
    unlock();
    wr(`MIL_OFS_EVLOCK, 32'h01);
    rchk(`MIL_OFS_EVLOCK, 8'h01, "lower lock reg");
    chk(32'(lower_channels_lock_o), 32'h1, "lower lock out");
    strobe(8'hff, 2'b11, 8'hf0, 2'b11);
    unlock();
    wr(`MIL_OFS_EVLOCK, 32'h11);
    chk(32'(upper_channels_lock_o), 32'h1, "upper lock out");
    strobe(8'hff, 2'b11, 8'h00, 2'b11);
    unlock();
    wr(`MIL_OFS_WVLOCK, 32'h01);
    chk(32'(timer_c0_wave_lock_o), 32'h1, "c0 lock out");
    strobe(8'h00, 2'b11, 8'h00, 2'b10);
    unlock();
    wr(`MIL_OFS_WVLOCK, 32'h05);
    chk(32'(timer_e0_wave_lock_o), 32'h1, "e0 lock out");
    strobe(8'h00, 2'b11, 8'h00, 2'b00);
    unlock();
    wr(`MIL_OFS_EVLOCK, 32'h00);
    rchk(`MIL_OFS_EVLOCK, 8'h11, "event lock sticks");
    unlock();
    wr(`MIL_OFS_WVLOCK, 32'h00);
    rchk(`MIL_OFS_WVLOCK, 8'h05, "wave lock sticks");
    $display("test locks done");
  endtask

  task automatic run_ana(input logic [1:0] m, input int n_exp);
    int n;
    n = 0;
    @(posedge clk_i);
    ana_en_i <= m;
    @(posedge clk_i);
    #1;
    chk(32'(ana_ref_o & m), 32'(m), "reference on");
    while ((ana_bias_o & m) !== m && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(32'(n), 32'(n_exp), "bias delay");
    rchk(`MIL_OFS_ANASTAT, {2'b00, m, 2'b00, m}, "analog status");
    @(posedge clk_i);
    ana_en_i <= 2'b00;
    @(posedge clk_i);
    #1;
    chk(32'((ana_ref_o | ana_bias_o) & m), 32'h0, "analog off");
  endtask

  task automatic t_ana;
    int dly[4];
    dly = '{0, 2, 8, 32};
    for (int c = 0; c < 4; c++) begin
      wr(`MIL_OFS_ANA, 32'(c));
      run_ana(2'b01, dly[c]);
    end
    wr(`MIL_OFS_ANA, 32'h08);
    rchk(`MIL_OFS_ANA, 8'h08, "delay reg");
    run_ana(2'b10, 8);
    $display("test analog done");
  endtask

  task automatic t_reset;
    rchk(`MIL_OFS_EVLOCK, 8'h00, "event lock after reset");
    rchk(`MIL_OFS_WVLOCK, 8'h00, "wave lock after reset");
    rchk(`MIL_OFS_MCUCTL, 8'h00, "control after reset");
    rchk(`MIL_OFS_ANA, 8'h00, "delay after reset");
    wr(8'h3c, 32'hff);
    rchk(8'h3c, 8'h00, "unmapped");
    rchk(`MIL_OFS_IDENT0, ID0, "ident0 after reset");
    $display("test reset done");
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    do_reset();
    t_id();
    t_uid();
    t_scan();
    t_locks();
    t_ana();
    do_reset();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
